/* src/rac_pkg.sv */
// Constants shared by the radio auxiliary control register bank.
`default_nettype none

package rac_pkg;

    // ----------
    // Register port geometry
    // ----------
    localparam int ADDR_W = 10;
    localparam int DATA_W = 8;

    // ----------
    // Register offsets
    // ----------
    localparam logic [ADDR_W-1:0] OFS_RECEIVED_POWER_LEVEL    = 10'h312;
    localparam logic [ADDR_W-1:0] OFS_FREQ_PULL_IN_LIMIT      = 10'h315;
    localparam logic [ADDR_W-1:0] OFS_IMAGE_CAL_SOURCE_CONFIG = 10'h319;
    localparam logic [ADDR_W-1:0] OFS_SHUTDOWN_REQUEST        = 10'h322;
    localparam logic [ADDR_W-1:0] OFS_RECEIVE_CHAIN_POWER     = 10'h324;
    localparam logic [ADDR_W-1:0] OFS_MONITOR_POWER           = 10'h325;
    localparam logic [ADDR_W-1:0] OFS_CONVERTER_RESULT_UPPER  = 10'h327;
    localparam logic [ADDR_W-1:0] OFS_CONVERTER_RESULT_LOWER  = 10'h328;
    localparam logic [ADDR_W-1:0] OFS_SUPPLY_ALARM_THRESHOLD  = 10'h32D;
    localparam logic [ADDR_W-1:0] OFS_INTERRUPT_SOURCE_1      = 10'h337;

    // ----------
    // Field positions and masks
    // ----------
    localparam int IMG_OVR_BIT      = 5;
    localparam int IMG_FREQ_LSB     = 3;
    localparam int IMG_FREQ_W       = 2;
    localparam int IMG_POWER_LSB    = 0;
    localparam int IMG_POWER_W      = 3;
    localparam int SHUTDOWN_BIT     = 0;
    localparam int RX_CHAIN_W       = 5;
    localparam int RX_ADC_BIT       = 4;
    localparam int RX_DET_BIT       = 3;
    localparam int RX_FILT_BIT      = 2;
    localparam int RX_MIX_BIT       = 1;
    localparam int RX_LNA_BIT       = 0;
    localparam int MON_TEMP_BIT     = 1;
    localparam int MON_SUPPLY_BIT   = 0;
    localparam int TRIP_CODE_W      = 5;
    localparam int ALARM_BIT        = 7;
    localparam int ADC_UPPER_W      = 6;
    localparam int ADC_LOWER_W      = 2;

    localparam logic [DATA_W-1:0] MASK_IMAGE_CAL  = 8'h3F;
    localparam logic [DATA_W-1:0] MASK_SHUTDOWN   = 8'h01;
    localparam logic [DATA_W-1:0] MASK_RX_CHAIN   = 8'h1F;
    localparam logic [DATA_W-1:0] MASK_MONITOR    = 8'h03;
    localparam logic [DATA_W-1:0] MASK_TRIP_CODE  = 8'h1F;

    // ----------
    // Reset values and conversion constants
    // ----------
    localparam logic [DATA_W-1:0] RST_ZERO           = 8'h00;
    localparam logic [DATA_W-1:0] RST_PULL_IN_LIMIT  = 8'h32;
    localparam logic [8:0]        RSSI_OFFSET_DBM    = 9'h06B;
    localparam int                IF_BW_W            = 9;
    localparam int                SYNC_STAGES        = 3;

endpackage : rac_pkg

`default_nettype wire

/* src/rac_pin_sync.sv */
// Three-stage pin synchroniser with agreement filter, one per input bit.
`default_nettype none

module rac_pin_sync
    import rac_pkg::*;
#(
    parameter int WIDTH = 2
) (
    // Clock and reset
    input  wire logic             sys_clk,
    input  wire logic             reset,
    // Asynchronous pins and their settled levels
    input  wire logic [WIDTH-1:0] pin_in,
    output logic      [WIDTH-1:0] level_out
);

    // ----------
    // Per-bit synchroniser chain
    // ----------
    genvar g;
    generate
        for (g = 0; g < WIDTH; g = g + 1) begin : g_bit
            logic [SYNC_STAGES-1:0] chain_r;
            logic                   level_r;

            // Stage 0 feeds only stage 1; stages 1 and 2 vote on a change.
            always_ff @(posedge sys_clk or posedge reset) begin
                if (reset) begin
                    chain_r <= '0;
                    level_r <= 1'b0;
                end else begin
                    chain_r <= {chain_r[SYNC_STAGES-2:0], pin_in[g]};
                    if (chain_r[1] == chain_r[2]) begin
                        level_r <= chain_r[2];
                    end
                end
            end

            assign level_out[g] = level_r;
        end
    endgenerate

endmodule : rac_pin_sync

`default_nettype wire

/* src/rac_regs.sv */
// Radio auxiliary control register bank.
//
// Function
// [R1] Received power code latched on packet reception; dBm equals code minus 107.
// [R2] Pull-in limit loaded on receive entry as half IF bandwidth; resets 50, read-only.
// [R3] Two-bit field selects calibration tone: off, crystal/4, crystal/8, crystal/16.
// [R4] Three-bit tone level: off, then min, twice, three times, four times.
// [R5] Override bit lets host calibration results replace internal ones; resets 0.
// [R6] Shutdown request starts shutdown only while chip select is high.
// [R7] Five receive-chain power enables, active high, reset off.
// [R8] Temperature and supply monitor enables, active high, reset off.
// [R9] ADC result split: bits 7:2 in upper byte, bits 1:0 in lower.
// [R10] Five-bit trip code sets alarm at 1.7 V plus 62 mV times code+1.
// [R11] Supply below trip level raises alarm to host through interrupt path.
// [R12] Alarm appears as bit 7 of second interrupt source register.
// [R13] Reserved bits read zero and ignore writes.
`default_nettype none

module rac_regs
    import rac_pkg::*;
(
    // Clock and reset
    input  wire logic                 sys_clk,
    input  wire logic                 reset,
    // Register port
    input  wire logic [ADDR_W-1:0]    reg_addr,
    input  wire logic                 reg_wr,
    input  wire logic [DATA_W-1:0]    reg_wdata,
    input  wire logic                 reg_rd,
    output logic      [DATA_W-1:0]    reg_rdata,
    // Serial chip select pin, high when the host releases the bus
    input  wire logic                 spi_cs_pin,
    // Receive path status
    input  wire logic                 packet_received,
    input  wire logic [DATA_W-1:0]    received_power_code_in,
    input  wire logic                 receive_state_entry,
    input  wire logic [IF_BW_W-1:0]   if_bandwidth_khz,
    // Converter result
    input  wire logic                 converter_valid,
    input  wire logic [DATA_W-1:0]    converter_result,
    // Supply comparator pin, high while supply is below trip level
    input  wire logic                 supply_below_pin,
    // Readback and calibration controls
    output logic signed [8:0]         received_power_dbm,
    output logic      [DATA_W-1:0]    pull_in_limit,
    output logic                      image_cal_override_enable,
    output logic      [IMG_FREQ_W-1:0] image_cal_freq_sel,
    output logic                      image_cal_source_on,
    output logic      [2:0]           image_cal_div_log2,
    output logic      [2:0]           image_cal_level_mult,
    // Chip state control
    output logic                      shutdown_invoke,
    // Receive chain power enables
    output logic                      converter_power_enable,
    output logic                      power_detector_enable,
    output logic                      if_filter_enable,
    output logic                      mixer_enable,
    output logic                      low_noise_amp_enable,
    // Monitor enables and alarm
    output logic                      temperature_monitor_enable,
    output logic                      supply_monitor_enable,
    output logic      [TRIP_CODE_W-1:0] supply_trip_code,
    output logic                      supply_alarm_event,
    output logic                      supply_alarm_flag
);

    // ----------
    // Storage
    // ----------
    logic [DATA_W-1:0]      power_code_r;
    logic [DATA_W-1:0]      pull_in_r;
    logic [5:0]             image_cfg_r;
    logic                   shutdown_bit_r;
    logic [RX_CHAIN_W-1:0]  rx_chain_r;
    logic [1:0]             monitor_r;
    logic [DATA_W-1:0]      adc_r;
    logic [TRIP_CODE_W-1:0] trip_code_r;
    logic                   alarm_flag_r;
    logic                   alarm_flag_nxt;
    logic                   below_seen_r;
    logic                   alarm_event_r;
    logic                   shutdown_r;
    logic [DATA_W-1:0]      rdata_r;
    logic [DATA_W-1:0]      rdata_nxt;
    logic [2:0]             div_log2_r;
    logic [2:0]             level_mult_r;

    // ----------
    // Pin synchronisation
    // ----------
    logic [1:0] pin_level;

    // Both pins are asynchronous to the clock.
    rac_pin_sync #(
        .WIDTH     (2)
    ) u_pin_sync (
        .sys_clk   (sys_clk),
        .reset     (reset),
        .pin_in    ({supply_below_pin, spi_cs_pin}),
        .level_out (pin_level)
    );

    wire cs_high      = pin_level[0];
    wire supply_below = pin_level[1];

    // ----------
    // Address decode
    // ----------
    wire hit_power   = (reg_addr == OFS_RECEIVED_POWER_LEVEL);
    wire hit_pull    = (reg_addr == OFS_FREQ_PULL_IN_LIMIT);
    wire hit_image   = (reg_addr == OFS_IMAGE_CAL_SOURCE_CONFIG);
    wire hit_shut    = (reg_addr == OFS_SHUTDOWN_REQUEST);
    wire hit_rx      = (reg_addr == OFS_RECEIVE_CHAIN_POWER);
    wire hit_mon     = (reg_addr == OFS_MONITOR_POWER);
    wire hit_adc_hi  = (reg_addr == OFS_CONVERTER_RESULT_UPPER);
    wire hit_adc_lo  = (reg_addr == OFS_CONVERTER_RESULT_LOWER);
    wire hit_trip    = (reg_addr == OFS_SUPPLY_ALARM_THRESHOLD);
    wire hit_irq1    = (reg_addr == OFS_INTERRUPT_SOURCE_1);

    // Write strobes; read-only registers have none, so host writes there vanish.
    wire wr_image    = reg_wr & hit_image;
    wire wr_shut     = reg_wr & hit_shut;
    wire wr_rx       = reg_wr & hit_rx;
    wire wr_mon      = reg_wr & hit_mon;
    wire wr_trip     = reg_wr & hit_trip;
    wire wr_irq1     = reg_wr & hit_irq1;

    // Writable fields with reserved bits stripped.
    wire [DATA_W-1:0] wdata_image = reg_wdata & MASK_IMAGE_CAL;    // see [R13]
    wire [DATA_W-1:0] wdata_shut  = reg_wdata & MASK_SHUTDOWN;     // see [R13]
    wire [DATA_W-1:0] wdata_rx    = reg_wdata & MASK_RX_CHAIN;     // see [R13]
    wire [DATA_W-1:0] wdata_mon   = reg_wdata & MASK_MONITOR;      // see [R13]
    wire [DATA_W-1:0] wdata_trip  = reg_wdata & MASK_TRIP_CODE;    // see [R13]

    // ----------
    // Receive readbacks
    // ----------
    // Half the IF bandwidth in kHz, cut to the register width.
    wire [IF_BW_W-1:0] half_bw = if_bandwidth_khz >> 1;
    wire [DATA_W-1:0]  pull_in_nxt = half_bw[DATA_W-1:0];

    // Power code is captured when a packet completes.
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            power_code_r <= RST_ZERO;
        end else if (packet_received) begin
            power_code_r <= received_power_code_in;                // see [R1]
        end
    end

    // Pull-in limit reloads on each receive entry; the host cannot write it.
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            pull_in_r <= RST_PULL_IN_LIMIT;
        end else if (receive_state_entry) begin
            pull_in_r <= pull_in_nxt;    // see [R2]
        end
    end

    // Converter result is held between conversions.
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            adc_r <= RST_ZERO;
        end else if (converter_valid) begin
            adc_r <= converter_result;
        end
    end

    // Offset to dBm, zero-extended from the unsigned code.
    assign received_power_dbm = $signed({1'b0, power_code_r}) - $signed(RSSI_OFFSET_DBM); // see [R1]
    assign pull_in_limit      = pull_in_r;

    // ----------
    // Host-writable configuration
    // ----------
    // Calibration source configuration.
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            image_cfg_r <= 6'h00;
        end else if (wr_image) begin
            image_cfg_r <= wdata_image[5:0];                       // see [R5]
        end
    end

    // Shutdown request bit.
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            shutdown_bit_r <= 1'b0;
        end else if (wr_shut) begin
            shutdown_bit_r <= wdata_shut[SHUTDOWN_BIT];
        end
    end

    // Receive chain and monitor power enables.
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            rx_chain_r <= 5'h00;
            monitor_r  <= 2'h0;
        end else begin
            if (wr_rx) begin
                rx_chain_r <= wdata_rx[RX_CHAIN_W-1:0];            // see [R7]
            end
            if (wr_mon) begin
                monitor_r <= wdata_mon[1:0];                       // see [R8]
            end
        end
    end

    // Supply alarm trip code.
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            trip_code_r <= 5'h00;
        end else if (wr_trip) begin
            trip_code_r <= wdata_trip[TRIP_CODE_W-1:0];            // see [R10]
        end
    end

    // ----------
    // Calibration tone decode
    // ----------
    wire [IMG_FREQ_W-1:0]  freq_sel  = image_cfg_r[IMG_FREQ_LSB +: IMG_FREQ_W];
    wire [IMG_POWER_W-1:0] power_sel = image_cfg_r[IMG_POWER_LSB +: IMG_POWER_W];
    // Codes 1,2,3 divide by 4,8,16, so the shift is code plus one.
    wire [2:0] div_log2_nxt  = (freq_sel == 2'h0) ? 3'h0 : ({1'b0, freq_sel} + 3'h1);
    // Level multiple is the code plus one, halved: 1,1,2,2,3,3,4.
    wire [3:0] level_sum     = {1'b0, power_sel} + 4'h1;
    wire [2:0] level_mult_nxt = (power_sel == 3'h0) ? 3'h0 : level_sum[3:1];

    // Registered tone controls for the analog source.
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            div_log2_r   <= 3'h0;
            level_mult_r <= 3'h0;
        end else begin
            div_log2_r   <= div_log2_nxt;                          // see [R3]
            level_mult_r <= level_mult_nxt;                        // see [R4]
        end
    end

    assign image_cal_override_enable = image_cfg_r[IMG_OVR_BIT];  // see [R5]
    assign image_cal_freq_sel        = freq_sel;
    assign image_cal_source_on       = (div_log2_r != 3'h0);       // see [R3]
    assign image_cal_div_log2        = div_log2_r;
    assign image_cal_level_mult      = level_mult_r;

    // ----------
    // Chip shutdown
    // ----------
    // Shutdown goes ahead only once the host has released chip select.
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            shutdown_r <= 1'b0;
        end else begin
            shutdown_r <= shutdown_bit_r & cs_high;                // see [R6]
        end
    end

    assign shutdown_invoke = shutdown_r;

    // ----------
    // Power enable outputs
    // ----------
    assign converter_power_enable     = rx_chain_r[RX_ADC_BIT];    // see [R7]
    assign power_detector_enable      = rx_chain_r[RX_DET_BIT];
    assign if_filter_enable           = rx_chain_r[RX_FILT_BIT];
    assign mixer_enable               = rx_chain_r[RX_MIX_BIT];
    assign low_noise_amp_enable       = rx_chain_r[RX_LNA_BIT];
    assign temperature_monitor_enable = monitor_r[MON_TEMP_BIT];   // see [R8]
    assign supply_monitor_enable      = monitor_r[MON_SUPPLY_BIT];
    assign supply_trip_code           = trip_code_r;               // see [R10]

    // ----------
    // Supply alarm
    // ----------
    // A fresh low-supply indication while the monitor runs is one event.
    wire below_gated  = supply_below & monitor_r[MON_SUPPLY_BIT];
    wire alarm_rise   = below_gated & ~below_seen_r;               // see [R11]
    wire alarm_clear  = wr_irq1 & reg_wdata[ALARM_BIT];

    // Set wins over a host clear arriving in the same cycle.
    assign alarm_flag_nxt = alarm_rise ? 1'b1 : (alarm_clear ? 1'b0 : alarm_flag_r);

    // Sticky alarm flag and its event pulse.
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            below_seen_r  <= 1'b0;
            alarm_event_r <= 1'b0;
            alarm_flag_r  <= 1'b0;
        end else begin
            below_seen_r  <= below_gated;
            alarm_event_r <= alarm_rise; // see [R11]
            alarm_flag_r  <= alarm_flag_nxt;                       // see [R12]
        end
    end

    assign supply_alarm_event = alarm_event_r;
    assign supply_alarm_flag  = alarm_flag_r;

    // ----------
    // Read path
    // ----------
    wire [DATA_W-1:0] rd_image = {2'b00, image_cfg_r};                        // see [R13]
    wire [DATA_W-1:0] rd_shut  = {7'h00, shutdown_bit_r};
    wire [DATA_W-1:0] rd_rx    = {3'h0, rx_chain_r};
    wire [DATA_W-1:0] rd_mon   = {6'h00, monitor_r};
    wire [DATA_W-1:0] rd_adc_h = {2'b00, adc_r[DATA_W-1 -: ADC_UPPER_W]};     // see [R9]
    wire [DATA_W-1:0] rd_adc_l = {adc_r[ADC_LOWER_W-1:0], 6'h00};             // see [R9]
    wire [DATA_W-1:0] rd_trip  = {3'h0, trip_code_r};
    wire [DATA_W-1:0] rd_irq1  = {alarm_flag_r, 7'h00};                       // see [R12]

    // Unmapped addresses read as zero.
    assign rdata_nxt = hit_power  ? power_code_r :
                       hit_pull   ? pull_in_r    :
                       hit_image  ? rd_image     :
                       hit_shut   ? rd_shut      :
                       hit_rx     ? rd_rx        :
                       hit_mon    ? rd_mon       :
                       hit_adc_hi ? rd_adc_h     :
                       hit_adc_lo ? rd_adc_l     :
                       hit_trip   ? rd_trip      :
                       hit_irq1   ? rd_irq1      : RST_ZERO;

    // Read data is held until the next read.
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            rdata_r <= RST_ZERO;
        end else if (reg_rd) begin
            rdata_r <= rdata_nxt;
        end
    end

    assign reg_rdata = rdata_r;

endmodule : rac_regs

`default_nettype wire

/* tb/rac_regs_assertions.sv */
// Port checker for the radio auxiliary control register bank.
`default_nettype none
module rac_regs_chk
    import rac_pkg::*;
(
    // Clock, reset, register writes, chip select pin and pull-in limit
    input wire logic                   sys_clk, reset, reg_wr, spi_cs_pin,
    input wire logic [ADDR_W-1:0]      reg_addr,
    input wire logic [DATA_W-1:0]      reg_wdata, pull_in_limit,
    // Status inputs and decoded controls
    input wire logic                   receive_state_entry, shutdown_invoke,
    input wire logic [IF_BW_W-1:0]     if_bandwidth_khz,
    input wire logic [IMG_FREQ_W-1:0]  image_cal_freq_sel,
    input wire logic [2:0]             image_cal_div_log2,
    input wire logic                   image_cal_override_enable, low_noise_amp_enable,
    input wire logic                   converter_power_enable, supply_monitor_enable,
    input wire logic [TRIP_CODE_W-1:0] supply_trip_code,
    input wire logic                   supply_alarm_event, supply_alarm_flag
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    // Write strobes per register.
    wire wr_img = reg_wr && reg_addr == OFS_IMAGE_CAL_SOURCE_CONFIG;
    wire wr_rx  = reg_wr && reg_addr == OFS_RECEIVE_CHAIN_POWER;
    wire wr_mon = reg_wr && reg_addr == OFS_MONITOR_POWER;
    wire wr_thr = reg_wr && reg_addr == OFS_SUPPLY_ALARM_THRESHOLD;

    a_rx_chain_write: assert property (wr_rx |=>
        converter_power_enable == $past(reg_wdata[4]) && low_noise_amp_enable == $past(reg_wdata[0]))
        else $error("rx enables");
    a_monitor_write: assert property (wr_mon |=> supply_monitor_enable == $past(reg_wdata[0]))
        else $error("monitor enable");
    a_trip_code_write: assert property (wr_thr |=> supply_trip_code == $past(reg_wdata[4:0]))
        else $error("trip code");
    a_override_write: assert property (wr_img |=>
        image_cal_override_enable == $past(reg_wdata[5]) && image_cal_freq_sel == $past(reg_wdata[4:3]))
        else $error("source fields");
    a_freq_decode: assert property ($stable(image_cal_freq_sel) |-> image_cal_div_log2 ==
        (image_cal_freq_sel == 2'h0 ? 3'h0 : 3'h1 + image_cal_freq_sel))
        else $error("divider decode");
    a_pull_in_load: assert property (receive_state_entry |=>
        pull_in_limit == $past(if_bandwidth_khz[8:1])) else $error("pull-in load");
    a_pull_in_hold: assert property (!receive_state_entry |=> $stable(pull_in_limit))
        else $error("pull-in hold");
    a_shutdown_gate: assert property (!spi_cs_pin [*6] |-> !shutdown_invoke)
        else $error("shutdown gate");
    a_alarm_flag_set: assert property (supply_alarm_event |->
        supply_alarm_flag && $past(supply_monitor_enable)) else $error("alarm flag");

    // Main scenarios reached.
    c_entry: cover property (receive_state_entry);
    c_shutdown: cover property (shutdown_invoke);
    c_alarm: cover property (supply_alarm_event);
endmodule : rac_regs_chk

bind rac_regs rac_regs_chk rac_regs_chk_inst (.*);
`default_nettype wire

/* tb/rac_host_model.sv */
// Host model: drives the register port and the serial chip select pin.
`default_nettype none
module rac_host_model
    import rac_pkg::*;
(
    // Clock and read data
    input  wire logic              sys_clk,
    input  wire logic [DATA_W-1:0] reg_rdata,
    // Register access and chip select
    output var logic [ADDR_W-1:0]  reg_addr,
    output var logic               reg_wr, reg_rd, spi_cs_pin,
    output var logic [DATA_W-1:0]  reg_wdata
);
    timeunit 1ns;
    timeprecision 1ns;

    // Idle bus at time zero, chip select released.
    initial begin
        reg_addr = 10'h000;
        reg_wdata = 8'h00;
        {reg_wr, reg_rd, spi_cs_pin} = 3'b001;
    end

    // One write; chip select is pulled low and left low afterwards.
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(negedge sys_clk);
        spi_cs_pin = 1'b0;
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge sys_clk);
        reg_wr = 1'b0;
        reg_wdata = ~d;
    endtask : wr

    // One read; data is taken after the edge that accepted the strobe.
    task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
        @(negedge sys_clk);
        spi_cs_pin = 1'b0;
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge sys_clk);
        reg_rd = 1'b0;
        d = reg_rdata;
    endtask : rd

    // Release chip select high, the only state in which shutdown may start.
    task automatic release_cs();
        @(negedge sys_clk);
        spi_cs_pin = 1'b1;
    endtask : release_cs
endmodule : rac_host_model
`default_nettype wire

/* tb/tb_top.sv */
// Self-checking bench for the radio auxiliary control register bank.
`default_nettype none
module tb_top
    import rac_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk, reset, packet_received, receive_state_entry, converter_valid, supply_below_pin;
    logic [DATA_W-1:0] received_power_code_in, converter_result;
    logic [IF_BW_W-1:0] if_bandwidth_khz;
    wire logic [ADDR_W-1:0] reg_addr;
    wire logic reg_wr, reg_rd, spi_cs_pin, shutdown_invoke, supply_alarm_flag;
    wire logic [DATA_W-1:0] reg_wdata, reg_rdata, pull_in_limit;
    wire logic signed [8:0] received_power_dbm;
    wire logic [2:0] image_cal_div_log2, image_cal_level_mult;
    wire logic [4:0] rx_en;
    wire logic [1:0] mon_en;
    int error_cnt = 0;
    int checks = 0;

    rac_host_model rac_host_model_inst (.*);
    rac_regs rac_regs_inst (.*, .converter_power_enable(rx_en[4]), .power_detector_enable(rx_en[3]),
        .if_filter_enable(rx_en[2]), .mixer_enable(rx_en[1]), .low_noise_amp_enable(rx_en[0]),
        .temperature_monitor_enable(mon_en[1]), .supply_monitor_enable(mon_en[0]),
        .image_cal_override_enable(), .image_cal_freq_sel(), .image_cal_source_on(),
        .supply_trip_code(), .supply_alarm_event());

    // Free-running 20 MHz clock.
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    // Compares one value and counts it.
    task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask : chk

    // Prints the counts and the verdict, then stops.
    task automatic give_verdict();
        $display("checks %0d, error_cnt %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : give_verdict

    // Reads one register and compares it.
    task automatic rchk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
        logic [DATA_W-1:0] d;
        rac_host_model_inst.rd(a, d);
        chk(d, exp);
    endtask : rchk

    // Reset values, including an unmapped byte.
    task automatic t_reset();
        logic [ADDR_W-1:0] ofs [10] = '{10'h312, 10'h315, 10'h319, 10'h322, 10'h324,
                                        10'h325, 10'h327, 10'h328, 10'h32D, 10'h300};
        chk(pull_in_limit, 9'h032);
        foreach (ofs[i]) rchk(ofs[i], ofs[i] == 10'h315 ? 8'h32 : 8'h00);
    endtask : t_reset

    // Writable fields, reserved bits and read-only places.
    task automatic t_rw();
        logic [ADDR_W-1:0] ofs [5] = '{10'h319, 10'h322, 10'h324, 10'h325, 10'h32D};
        logic [DATA_W-1:0] msk [5] = '{8'h3F, 8'h01, 8'h1F, 8'h03, 8'h1F};
        foreach (ofs[i]) begin
            rac_host_model_inst.wr(ofs[i], 8'hFF);
            rchk(ofs[i], msk[i]);
        end
        chk(rx_en, 9'h01F);
        chk(mon_en, 9'h003);
        rac_host_model_inst.wr(10'h324, 8'h0A);
        chk(rx_en, 9'h00A);
        rac_host_model_inst.wr(10'h315, 8'hFF);
        rac_host_model_inst.wr(10'h312, 8'hFF);
        rchk(10'h315, 8'h32);
        rchk(10'h312, 8'h00);
        rac_host_model_inst.wr(10'h322, 8'h00);
    endtask : t_rw

    // Power code, pull-in load and split converter result.
    task automatic t_status();
        @(negedge sys_clk);
        {packet_received, receive_state_entry, converter_valid} = 3'b111;
        received_power_code_in = 8'h9C;
        if_bandwidth_khz = 9'h0C9;
        converter_result = 8'hB7;
        @(negedge sys_clk);
        {packet_received, receive_state_entry, converter_valid} = 3'b000;
        received_power_code_in = 8'h63;
        converter_result = 8'h48;
        chk(received_power_dbm, 9'h031);
        chk(pull_in_limit, 9'h064);
        rchk(10'h312, 8'h9C);
        rchk(10'h327, 8'h2D);
        rchk(10'h328, 8'hC0);
    endtask : t_status

    // Every tone divider and level code.
    task automatic t_tone();
        for (int k = 0; k < 8; k++) begin
            rac_host_model_inst.wr(10'h319, 8'(k * 9));
            @(negedge sys_clk);
            chk(image_cal_level_mult, 9'((k + 1) / 2));
            chk(image_cal_div_log2, 9'((k % 4 == 0) ? 0 : k % 4 + 1));
        end
    endtask : t_tone

    // Shutdown held off until chip select is released.
    task automatic t_shutdown();
        rac_host_model_inst.wr(10'h322, 8'h01);
        repeat (8) @(negedge sys_clk);
        chk(shutdown_invoke, 9'h000);
        rac_host_model_inst.release_cs();
        repeat (8) @(negedge sys_clk);
        chk(shutdown_invoke, 9'h001);
        rac_host_model_inst.wr(10'h322, 8'h00);
        @(negedge sys_clk);
        chk(shutdown_invoke, 9'h000);
    endtask : t_shutdown

    // Alarm masked while the monitor is off, then raised and cleared.
    task automatic t_alarm();
        int i;
        rac_host_model_inst.wr(10'h325, 8'h00);
        supply_below_pin = 1'b1;
        repeat (8) @(negedge sys_clk);
        chk(supply_alarm_flag, 9'h000);
        supply_below_pin = 1'b0;
        rac_host_model_inst.wr(10'h32D, 8'h0F);
        rac_host_model_inst.wr(10'h325, 8'h01);
        repeat (8) @(negedge sys_clk);
        supply_below_pin = 1'b1;
        for (i = 0; i < 20 && supply_alarm_flag !== 1'b1; i++) @(negedge sys_clk);
        if (i == 20) begin
            error_cnt++;
            give_verdict();
        end
        rchk(10'h337, 8'h80);
        supply_below_pin = 1'b0;
        rac_host_model_inst.wr(10'h337, 8'h80);
        rchk(10'h337, 8'h00);
    endtask : t_alarm

    // Main sequence.
    initial begin
        {reset, packet_received, receive_state_entry, converter_valid, supply_below_pin} = 5'h10;
        received_power_code_in = 8'h00;
        converter_result = 8'h00;
        if_bandwidth_khz = 9'h000;
        repeat (16) @(negedge sys_clk);
        reset = 1'b0;
        t_reset();
        t_rw();
        t_status();
        t_tone();
        t_shutdown();
        t_alarm();
        give_verdict();
    end
endmodule : tb_top
`default_nettype wire
